// [logic/interrupt_control_config.sv]
/*
 * configuration register of an interrupt controller: delivery scheme,
 * proximity timer threshold and external interrupt edge polarity, with
 * a sticky event status, mask and one level interrupt output.
 * assumes a plain register port synchronous to clk_sys, one strobe a
 * cycle, and external inputs already synchronous.
 */
`include "intctl_regs.svh"

module interrupt_control_config (
	input wire logic clk_sys,
	input wire logic resetn,
	input intctl_pkg::reg_req_s reg_req,
	output logic [31:0] rdata,
	input wire logic [4:0] ext_irq,
	input intctl_pkg::prio_req_s prio_req,
	output intctl_pkg::delivery_e delivery_mode,
	output logic [2:0] proximity_timer_threshold,
	output logic [4:0] ext_irq_event,
	output logic proximity_start,
	output logic irq
);
	import intctl_pkg::*;

	// state of this module; edge_detect and prox_check hold their own
	typedef struct packed {
		logic [31:0] interrupt_control; // only writable bits ever set
		logic [5:0] status; // sticky events
		logic [5:0] mask; // one enables the event onto irq
		logic [31:0] rdata; // read data, valid the cycle after rd
		logic irq; // registered interrupt level
		logic [4:0] evt; // registered edge events out
		logic prox; // registered proximity start
	} top_state_s;

	top_state_s st_q, st_d;

	logic [4:0] edge_pulse; // edges found under current polarity
	logic prox_pulse; // proximity start decision
	logic [5:0] events; // all event sources this cycle

	// field helpers
	function automatic logic [2:0] thresh_of(input logic [31:0] r);
		return r[`POS_THRESH_HI:`POS_THRESH_LO];
	endfunction

	function automatic logic [4:0] edges_of(input logic [31:0] r);
		return r[`POS_EDGE_HI:`POS_EDGE_LO];
	endfunction

	// edge detection for the five external inputs
	edge_detect u_edge (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.level_in(ext_irq),
		.rising_sel(edges_of(st_q.interrupt_control)),
		.edge_pulse(edge_pulse)
	);

	// proximity start decision from the threshold field
	prox_check u_prox (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.threshold(thresh_of(st_q.interrupt_control)),
		.req(prio_req),
		.start_pulse(prox_pulse)
	);

	assign events = {prox_pulse, edge_pulse};

	// register port, status capture and interrupt level
	always_comb begin
		logic wr_ctrl;
		logic wr_stat;
		logic [5:0] clr;
		wr_ctrl = 1'b0;
		wr_stat = 1'b0;
		clr = 6'h00;
		st_d = st_q;
		st_d.rdata = 32'h0000_0000;
		wr_ctrl = reg_req.wr && (reg_req.addr == `OFS_INTERRUPT_CONTROL);
		wr_stat = reg_req.wr && (reg_req.addr == `OFS_EVENT_STATUS);
		// writes touch only implemented bits
		if (wr_ctrl) begin
			st_d.interrupt_control = reg_req.wdata &
				`CTRL_WRITE_MASK;
		end
		if (reg_req.wr && (reg_req.addr == `OFS_EVENT_MASK)) begin
			st_d.mask = reg_req.wdata[5:0];
		end
		if (wr_stat) begin
			clr = reg_req.wdata[5:0];
		end
		// a new event beats a clear in the same cycle
		st_d.status = (st_q.status & ~clr) | events;
		// reads: unmapped offsets return zero
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				`OFS_INTERRUPT_CONTROL: begin
					st_d.rdata = st_q.interrupt_control &
						`CTRL_WRITE_MASK;
				end
				`OFS_EVENT_STATUS: begin
					st_d.rdata = {26'h000_0000, st_q.status};
				end
				`OFS_EVENT_MASK: begin
					st_d.rdata = {26'h000_0000, st_q.mask};
				end
				`OFS_PROX_STATE: begin
					st_d.rdata = {31'h0000_0000, st_q.prox};
				end
				default: begin
					st_d.rdata = 32'h0000_0000;
				end
			endcase
		end
		st_d.irq = |(st_d.status & st_d.mask);
		st_d.evt = edge_pulse;
		st_d.prox = prox_pulse;
	end

	// reset leaves single vectoring, timer off, all falling edge
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// mode output straight from the stored bit
	assign delivery_mode =
		delivery_e'(st_q.interrupt_control[`POS_MULTI_VECTOR]);
	assign proximity_timer_threshold = thresh_of(st_q.interrupt_control);
	assign ext_irq_event = st_q.evt;
	assign proximity_start = st_q.prox;
	assign irq = st_q.irq;
	assign rdata = st_q.rdata;
endmodule // interrupt_control_config

// [logic/intctl_regs.svh]
/*
 * register offsets, field positions, reset values and field widths for
 * the interrupt control configuration block.
 * assumes a plain register port with byte offsets and 32-bit data.
 */
`ifndef INTCTL_REGS_SVH
`define INTCTL_REGS_SVH

// register offsets (byte addresses)
`define OFS_INTERRUPT_CONTROL 8'h00
`define OFS_EVENT_STATUS 8'h04
`define OFS_EVENT_MASK 8'h08
`define OFS_PROX_STATE 8'h0C

// field positions inside interrupt_control
`define POS_MULTI_VECTOR 12
`define POS_THRESH_HI 10
`define POS_THRESH_LO 8
`define POS_EDGE_HI 4
`define POS_EDGE_LO 0

// writable bits of interrupt_control; the rest read zero
`define CTRL_WRITE_MASK 32'h0000_171F
`define CTRL_RESET 32'h0000_0000

// field widths
`define NUM_EXT_IRQ 5
`define THRESH_W 3
`define PRIO_W 3

// event status bits
`define EVT_W 6
`define EVT_PROX 5

`endif

// [logic/intctl_pkg.sv]
/*
 * types shared by the interrupt control configuration block.
 * assumes the register header is compiled alongside.
 */
package intctl_pkg;

	// delivery scheme to the core
	typedef enum logic [0:0] {
		DELIV_SINGLE = 1'b0,
		DELIV_MULTI = 1'b1
	} delivery_e;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// a pending interrupt as presented for proximity checking
	typedef struct packed {
		logic valid;
		logic [2:0] group_prio;
	} prio_req_s;

endpackage

// [logic/edge_detect.sv]
/*
 * per-input edge detector with selectable polarity.
 * assumes inputs are synchronous to clk_sys.
 */
module edge_detect (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [4:0] level_in,
	input wire logic [4:0] rising_sel,
	output logic [4:0] edge_pulse
);
	import intctl_pkg::*;

	typedef struct packed {
		logic [4:0] prev;
		logic [4:0] pulse;
	} ed_state_s;

	ed_state_s st_q, st_d;

	// a one selects rising, a zero falling, per input
	always_comb begin
		st_d = st_q;
		st_d.prev = level_in;
		st_d.pulse = (rising_sel & level_in & ~st_q.prev) |
			(~rising_sel & ~level_in & st_q.prev);
	end

	// prev resets low: reset polarity is falling, which needs prev high,
	// so no false fall can follow reset whatever level the pin idles at
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			st_q <= '{prev: 5'h00, pulse: 5'h00};
		end else begin
			st_q <= st_d;
		end
	end

	assign edge_pulse = st_q.pulse;
endmodule // edge_detect

// [logic/prox_check.sv]
/*
 * decides whether a pending interrupt's group priority starts the
 * proximity timer under the current threshold code.
 * assumes the request is synchronous to clk_sys.
 */
module prox_check (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [2:0] threshold,
	input intctl_pkg::prio_req_s req,
	output logic start_pulse
);
	import intctl_pkg::*;

	typedef struct packed {
		logic start;
	} pc_state_s;

	pc_state_s st_q, st_d;

	// code 0 disables, 1 matches priority 1 only, else prio <= code
	function automatic logic starts(input logic [2:0] code,
		input logic [2:0] prio);
		logic r;
		r = 1'b0;
		if (code == 3'h0) begin
			r = 1'b0;
		end else if (code == 3'h1) begin
			r = (prio == 3'h1);
		end else begin
			r = (prio <= code);
		end
		return r;
	endfunction

	// registered so the output is clean
	always_comb begin
		st_d.start = req.valid && starts(threshold, req.group_prio);
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			st_q <= '{start: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign start_pulse = st_q.start;
endmodule // prox_check

// [tb/intctl_cfg_asserts.sv]
/* port checker for the interrupt control block.
   assumes one clock domain and a sync active-low reset. */
module intctl_cfg_asserts (
	input wire logic clk_sys,
	input wire logic resetn,
	input intctl_pkg::reg_req_s reg_req,
	input wire logic [31:0] rdata,
	input wire logic [4:0] ext_irq,
	input intctl_pkg::prio_req_s prio_req,
	input intctl_pkg::delivery_e delivery_mode,
	input wire logic [2:0] proximity_timer_threshold,
	input wire logic [4:0] ext_irq_event,
	input wire logic proximity_start,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	import intctl_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic [4:0] pol_q; // polarity as last written
	sequence s_ctl_wr;
		reg_req.wr && reg_req.addr == 8'h00;
	endsequence
	// mirror polarity, edges cannot be judged without it
	always_ff @(posedge clk_sys) begin
		if (!resetn)
			pol_q <= 5'h0;
		else if (reg_req.wr && reg_req.addr == 8'h00)
			pol_q <= reg_req.wdata[4:0];
	end
	a_mode_write: assert property (
		s_ctl_wr |=> delivery_mode == $past(reg_req.wdata[12]))
		else $error("mode not taken");
	a_thresh_write: assert property (
		s_ctl_wr |=> proximity_timer_threshold == $past(reg_req.wdata[10:8]))
		else $error("threshold not taken");
	a_low_prio_start: assert property (
		prio_req.valid && proximity_timer_threshold > 3'h1 &&
		prio_req.group_prio <= proximity_timer_threshold
		|-> ##2 proximity_start) else $error("start missing");
	a_code_one: assert property (
		prio_req.valid && proximity_timer_threshold == 3'h1 |-> ##2
		proximity_start == ($past(prio_req.group_prio, 2) == 3'h1))
		else $error("code one start wrong");
	a_timer_off: assert property (
		prio_req.valid && proximity_timer_threshold == 3'h0
		|-> ##2 !proximity_start) else $error("start while off");
	a_rise_seen: assert property (
		$rose(ext_irq[0]) && pol_q[0] |-> ##2 ext_irq_event[0])
		else $error("rise missed");
	a_fall_seen: assert property (
		$fell(ext_irq[1]) && !pol_q[1] |-> ##2 ext_irq_event[1])
		else $error("fall missed");
	a_unimpl_zero: assert property (
		reg_req.rd && reg_req.addr == 8'h00 |=>
		(rdata & ~32'h0000_171F) == 32'h0) else $error("bits not zero");
	a_reset_clear: assert property (disable iff (1'b0)
		!resetn |=> delivery_mode == DELIV_SINGLE &&
		proximity_timer_threshold == 3'h0) else $error("reset not clear");
endmodule // intctl_cfg_asserts
bind interrupt_control_config intctl_cfg_asserts u_chk (.*);

// [tb/core_model.sv]
/* core side: presents prioritised requests and counts timer starts.
   assumes the bench drives go and prio on the rising edge. */
module core_model (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic go,
	input wire logic [2:0] prio,
	input wire logic proximity_start,
	output intctl_pkg::prio_req_s prio_req,
	output int starts
);
	timeunit 1ns;
	timeprecision 1ns;
	import intctl_pkg::*;
	// priority toggles while idle so a stale value is never trusted
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			prio_req <= '0;
			starts <= 0;
		end else begin
			prio_req.valid <= go;
			prio_req.group_prio <= go ? prio : ~prio_req.group_prio;
			starts <= starts + int'(proximity_start);
		end
	end
endmodule // core_model

// [tb/tb.sv]
/* bench for the interrupt control block.
   assumes package and design are compiled first. */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import intctl_pkg::*;
	logic clk_sys, resetn, go, proximity_start, irq;
	reg_req_s reg_req;
	logic [31:0] rdata;
	logic [4:0] ext_irq, ext_irq_event, ev;
	logic [2:0] prio, proximity_timer_threshold;
	prio_req_s prio_req;
	delivery_e delivery_mode;
	int starts, mismatches, samples_checked, cycles;
	interrupt_control_config u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.reg_req(reg_req), .rdata(rdata), .ext_irq(ext_irq),
		.prio_req(prio_req), .delivery_mode(delivery_mode),
		.proximity_timer_threshold(proximity_timer_threshold),
		.ext_irq_event(ext_irq_event), .proximity_start(proximity_start),
		.irq(irq));
	core_model u_core (.clk_sys(clk_sys), .resetn(resetn), .go(go),
		.prio(prio), .proximity_start(proximity_start),
		.prio_req(prio_req), .starts(starts));
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: exp %h got %h", what, exp, got);
		end
	endtask
	// a spare cycle after each access keeps strobes from colliding
	task automatic wr(logic [7:0] a, logic [31:0] d);
		reg_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		reg_req.wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, string what);
		reg_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys);
		reg_req.rd <= 1'b0;
		@(negedge clk_sys);
		check(what, e, rdata);
		@(posedge clk_sys);
	endtask
	// gather event pulses away from the launching edge
	task automatic grab;
		ev = 5'h0;
		repeat (4) begin
			@(negedge clk_sys);
			ev |= ext_irq_event;
		end
		@(posedge clk_sys);
	endtask
	task automatic t_ctrl;
		rd(8'h00, 32'h0, "ctrl reset");
		wr(8'h00, 32'hFFFF_FFFF);
		rd(8'h00, 32'h0000_171F, "ctrl ones");
		check("mode", 32'(DELIV_MULTI), 32'(delivery_mode));
		check("thr", 32'h7, 32'(proximity_timer_threshold));
		rd(8'h10, 32'h0, "unmapped");
		$display("test ctrl done");
	endtask
	task automatic t_prox;
		int n;
		logic [31:0] e;
		for (int c = 0; c < 8; c++) begin
			wr(8'h00, {21'h0, c[2:0], 8'h00});
			for (int p = 0; p < 8; p++) begin
				n = starts;
				prio <= p[2:0];
				go <= 1'b1;
				@(posedge clk_sys);
				go <= 1'b0;
				repeat (5) @(posedge clk_sys);
				e = (c == 0) ? 0 : (c == 1) ? (p == 1) : (p <= c);
				check("start", e, 32'(starts - n));
			end
		end
		check("mode", 32'(DELIV_SINGLE), 32'(delivery_mode));
		$display("test prox done");
	endtask
	task automatic t_edge;
		wr(8'h04, 32'h0000_003F);
		wr(8'h08, 32'h0000_001F);
		wr(8'h00, 32'h0000_0015);
		ext_irq <= 5'h1F;
		grab;
		check("rise", 32'h15, 32'(ev));
		ext_irq <= 5'h0;
		grab;
		check("fall", 32'h0A, 32'(ev));
		rd(8'h04, 32'h0000_001F, "status");
		check("irq on", 32'h1, 32'(irq));
		wr(8'h08, 32'h0);
		@(negedge clk_sys);
		check("irq masked", 32'h0, 32'(irq));
		@(posedge clk_sys);
		wr(8'h04, 32'h0000_003F);
		rd(8'h04, 32'h0, "cleared");
		$display("test edge done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// hang guard, several times the expected run
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			report_and_stop;
		end
	end
	initial begin
		{resetn, go, prio, ext_irq} = '0;
		{reg_req, mismatches, samples_checked} = '0;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		t_ctrl;
		t_prox;
		t_edge;
		report_and_stop;
	end
endmodule // tb
